/* File: core/byte_fifo.sv */
// small synchronous fifo with valid/ready on both sides
// assumes one clock and async active-low reset
module byte_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             CLK,
  input  wire logic             RST_N,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  assign in_ready  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr_reg];

  always_ff @(posedge CLK) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // byte_fifo

/* File: core/ext_bus_pkg.sv */
// shared constants and types for the external memory bus and reset entry
// assumes one core clock; machine cycle is a fixed number of core clocks
package ext_bus_pkg;
  localparam int unsigned PHASES_PER_MC     = 6;
  localparam logic [2:0]  PHASE_LAST        = 3'h5;
  localparam int unsigned RESET_HOLD_MC     = 2;
  localparam int unsigned PROGRAM_PULSE_N_ENTRY_MC     = 10;
  localparam logic [3:0]  RESET_HOLD_CNT    = 4'h2;
  localparam logic [3:0]  PROGRAM_PULSE_N_ENTRY_CNT    = 4'ha;
  localparam logic [7:0]  PORT_RESET        = 8'hff;
  localparam int unsigned FIFO_DEPTH        = 8;
  localparam int unsigned DATA_W            = 8;
  localparam logic [15:0] EXT_ADDR_TOP      = 16'hffff;

  typedef enum logic [1:0] {
    ACC_FETCH,
    ACC_WIDE_MOVE,
    ACC_NARROW_MOVE
  } access_kind_t;

  typedef enum logic [2:0] {
    ST_RESET,
    ST_RESET_DONE,
    ST_RUN,
    ST_HOST_PROGRAM_PULSE_N
  } mode_t;
endpackage

/* File: core/ext_memory_bus.sv */
// external memory bus sequencer and reset / programming-mode entry
// assumes the core presents access requests on CLK; pins are synchronised
module ext_memory_bus (
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic        RST_PIN,
  input  wire logic        EXT_FETCH_SELECT_N,
  input  wire logic        SECURITY_LOCK,
  input  wire logic        REQ_VALID,
  output logic             REQ_READY,
  input  wire logic [1:0]  REQ_KIND,
  input  wire logic        REQ_WRITE,
  input  wire logic [15:0] REQ_ADDR,
  input  wire logic [7:0]  REQ_WDATA,
  input  wire logic        REQ_INTERNAL,
  output logic [7:0]       RDATA,
  output logic             RDATA_VALID,
  input  wire logic        RDATA_READY,
  input  wire logic [7:0]  PORT_ZERO_LATCH,
  input  wire logic [7:0]  PORT_TWO_LATCH,
  input  wire logic        SERIAL_OUT,
  output logic             SERIAL_IN,
  output logic             EXT_IRQ0_N,
  output logic             EXT_IRQ1_N,
  output logic             TIMER0_INPUT,
  output logic             TIMER1_INPUT,
  input  wire logic [7:0]  P0_IN,
  output logic [7:0]       P0_OUT,
  output logic [7:0]       P0_OE,
  output logic [7:0]       P2_OUT,
  output logic [7:0]       P3_OUT,
  input  wire logic [7:0]  P1_IN,
  input  wire logic [7:0]  P2_IN,
  input  wire logic [7:0]  P3_IN,
  output logic             ALE_OUT,
  output logic             ALE_OE,
  input  wire logic        ALE_IN,
  output logic             PROGRAM_FETCH_STROBE_N_OUT,
  output logic             PROGRAM_FETCH_STROBE_N_OE,
  input  wire logic        PROGRAM_FETCH_STROBE_N_IN,
  output logic             EXT_FETCH_ACTIVE,
  output logic             HOST_PROGRAM_PULSE_N_MODE,
  output logic             IN_RESET,
  output logic             PROGRAM_PULSE_N,
  output logic [15:0]      PROGRAM_PULSE_N_ADDR,
  output logic [7:0]       PROGRAM_PULSE_N_CODE,
  input  wire logic [7:0]  PROGRAM_PULSE_N_VERIFY_DATA,
  input  wire logic        PROGRAM_PULSE_N_VERIFY
);
  typedef struct packed {
    ext_bus_pkg::mode_t        mode;
    logic [3:0]                rst_cnt;
    logic [3:0]                phase_cnt;
    logic [2:0]                phase;
    logic                      ea_latched_n;
    logic                      strobe_prev;
    logic                      busy;
    ext_bus_pkg::access_kind_t kind;
    logic                      write;
    logic [15:0]               addr;
    logic [7:0]                wdata;
    logic [7:0]                p0_out;
    logic [7:0]                p0_oe;
    logic [7:0]                p2_out;
    logic                      ale;
    logic                      program_fetch_strobe_n_n;
    logic                      rd_n;
    logic                      wr_n;
    logic [7:0]                rdata;
    logic                      rvalid;
  } state_t;

  // two-flop synchronisers for every pin input
  logic [31:0] sync1_reg;
  logic [31:0] sync2_reg;
  logic [31:0] pins_raw;
  assign pins_raw = {P0_IN, P1_IN, P2_IN, P3_IN};
  logic [4:0]  ctl1_reg;
  logic [4:0]  ctl2_reg;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      ctl1_reg  <= 5'h1e;
      ctl2_reg  <= 5'h1e;
    end else begin
      sync1_reg <= pins_raw;
      sync2_reg <= sync1_reg;
      ctl1_reg  <= {PROGRAM_FETCH_STROBE_N_IN, ALE_IN, EXT_FETCH_SELECT_N,
                    SECURITY_LOCK, RST_PIN};
      ctl2_reg  <= ctl1_reg;
    end
  end

  logic [7:0] p0_s;
  logic [7:0] p1_s;
  logic [7:0] p2_s;
  logic [7:0] p3_s;
  logic       rst_s;
  logic       lock_s;
  logic       ea_s;
  logic       ale_s;
  logic       program_fetch_strobe_n_s;
  assign {p0_s, p1_s, p2_s, p3_s} = sync2_reg;
  assign {program_fetch_strobe_n_s, ale_s, ea_s, lock_s, rst_s} = ctl2_reg;

  // read data leaves through the fifo so the core can stall it
  logic       fifo_in_ready;
  logic       push_rd;
  logic [7:0] push_data;

  byte_fifo #(
    .WIDTH (ext_bus_pkg::DATA_W),
    .DEPTH (ext_bus_pkg::FIFO_DEPTH)
  ) u_rd_fifo (
    .CLK       (CLK),
    .RST_N     (RST_N),
    .in_data   (push_data),
    .in_valid  (push_rd),
    .in_ready  (fifo_in_ready),
    .out_data  (RDATA),
    .out_valid (RDATA_VALID),
    .out_ready (RDATA_READY)
  );

  state_t s_reg;
  state_t s_next;
  logic   ea_eff_n;
  logic   run_ok;

  always_comb begin
    ea_eff_n = lock_s ? s_reg.ea_latched_n : ea_s;
    run_ok   = (s_reg.mode == ext_bus_pkg::ST_RUN);
  end

  // a new access may start only if the fifo can take its read byte
  // taken only in the last phase, so the access owns a whole machine cycle
  assign REQ_READY = run_ok && !s_reg.busy && fifo_in_ready &&
                     (s_reg.phase == ext_bus_pkg::PHASE_LAST);

  always_comb begin
    s_next      = s_reg;
    s_next.strobe_prev = program_fetch_strobe_n_s;
    push_rd     = 1'b0;
    push_data   = s_reg.rdata;

    case (s_reg.mode)
      ext_bus_pkg::ST_RESET: begin
        if (rst_s) begin
          if (s_reg.rst_cnt != ext_bus_pkg::PROGRAM_PULSE_N_ENTRY_CNT) begin
            s_next.rst_cnt = s_reg.rst_cnt + 4'h1;
          end
        end else begin
          s_next.rst_cnt = '0;
        end
        if (s_reg.phase == ext_bus_pkg::PHASE_LAST && rst_s) begin
          s_next.phase_cnt = s_reg.phase_cnt + 4'h1;
          if (s_reg.phase_cnt + 4'h1 >= ext_bus_pkg::RESET_HOLD_CNT) begin
            s_next.mode = ext_bus_pkg::ST_RESET_DONE;
            s_next.ea_latched_n = ea_s;
          end
        end
        if (!rst_s) begin
          s_next.phase_cnt = '0;
        end
      end
      ext_bus_pkg::ST_RESET_DONE: begin
        if (!rst_s) begin
          s_next.mode = ext_bus_pkg::ST_RUN;
        end else begin
          if (s_reg.phase == ext_bus_pkg::PHASE_LAST &&
              s_reg.phase_cnt != ext_bus_pkg::PROGRAM_PULSE_N_ENTRY_CNT) begin
            s_next.phase_cnt = s_reg.phase_cnt + 4'h1;
          end
          if (s_reg.phase_cnt == ext_bus_pkg::PROGRAM_PULSE_N_ENTRY_CNT &&
              s_reg.strobe_prev && !program_fetch_strobe_n_s) begin
            s_next.mode = ext_bus_pkg::ST_HOST_PROGRAM_PULSE_N;
          end
        end
      end
      ext_bus_pkg::ST_HOST_PROGRAM_PULSE_N: begin
        if (!rst_s) begin
          s_next.mode = ext_bus_pkg::ST_RUN;
        end
      end
      default: begin
        if (rst_s) begin
          s_next.mode      = ext_bus_pkg::ST_RESET;
          s_next.phase_cnt = '0;
          s_next.busy      = 1'b0;
        end
      end
    endcase

    s_next.phase = (s_reg.phase == ext_bus_pkg::PHASE_LAST) ? 3'h0
                   : s_reg.phase + 3'h1;

    // defaults: general I/O behaviour of the ports
    s_next.ale    = 1'b0;
    s_next.program_fetch_strobe_n_n = 1'b1;
    s_next.rd_n   = 1'b1;
    s_next.wr_n   = 1'b1;
    s_next.p0_out = 8'h00;
    s_next.p0_oe  = ~PORT_ZERO_LATCH;
    s_next.p2_out = PORT_TWO_LATCH;

    if (REQ_VALID && REQ_READY) begin
      s_next.busy  = 1'b1;
      s_next.kind  = ext_bus_pkg::access_kind_t'(REQ_KIND);
      s_next.write = REQ_WRITE;
      s_next.addr  = REQ_ADDR;
      s_next.wdata = REQ_WDATA;
      if (ext_bus_pkg::access_kind_t'(REQ_KIND) == ext_bus_pkg::ACC_FETCH &&
          REQ_INTERNAL && ea_eff_n) begin
        s_next.busy = 1'b0;
      end else begin
        // address phase 0 is launched from the taking edge itself
        s_next.ale    = 1'b1;
        s_next.p0_out = REQ_ADDR[7:0];
        s_next.p0_oe  = 8'hff;
        if (ext_bus_pkg::access_kind_t'(REQ_KIND) !=
            ext_bus_pkg::ACC_NARROW_MOVE) begin
          s_next.p2_out = REQ_ADDR[15:8];
        end
      end
    end

    if (s_reg.busy && run_ok && s_reg.phase != ext_bus_pkg::PHASE_LAST) begin
      // phases 0-1 address, 2-4 data, 5 finish; two fetch strobes per cycle
      if (s_reg.kind != ext_bus_pkg::ACC_NARROW_MOVE) begin
        s_next.p2_out = s_reg.addr[15:8];
      end else begin
        s_next.p2_out = PORT_TWO_LATCH;
      end
      if (s_next.phase == 3'h1) begin
        // latch strobe already low while the address still stands
        s_next.p0_out = s_reg.addr[7:0];
        s_next.p0_oe  = 8'hff;
        s_next.ale    = 1'b0;
      end else if (s_reg.kind == ext_bus_pkg::ACC_FETCH) begin
        s_next.p0_oe  = 8'h00;
        s_next.program_fetch_strobe_n_n = !(s_next.phase == 3'h2 || s_next.phase == 3'h4);
      end else begin
        // data move: fetch strobes suppressed for this cycle
        s_next.program_fetch_strobe_n_n = 1'b1;
        s_next.p0_out = s_reg.write ? s_reg.wdata : 8'h00;
        s_next.p0_oe  = s_reg.write ? 8'hff : 8'h00;
        s_next.wr_n   = !(s_reg.write && s_next.phase != 3'h5);
        s_next.rd_n   = !(!s_reg.write && s_next.phase != 3'h5);
      end
      if (s_reg.phase == 3'h4 && !(s_reg.kind != ext_bus_pkg::ACC_FETCH &&
                                   s_reg.write)) begin
        s_next.rdata = p0_s;
      end
    end
    if (s_reg.busy && run_ok && s_reg.phase == ext_bus_pkg::PHASE_LAST) begin
      s_next.busy = 1'b0;
      push_rd = !(s_reg.kind != ext_bus_pkg::ACC_FETCH && s_reg.write);
    end

    if (s_reg.mode == ext_bus_pkg::ST_HOST_PROGRAM_PULSE_N) begin
      s_next.p0_out = PROGRAM_PULSE_N_VERIFY_DATA;
      s_next.p0_oe  = PROGRAM_PULSE_N_VERIFY ? 8'hff : 8'h00;
      s_next.p2_out = ext_bus_pkg::PORT_RESET;
    end
    if (s_reg.mode != ext_bus_pkg::ST_RUN &&
        s_reg.mode != ext_bus_pkg::ST_HOST_PROGRAM_PULSE_N) begin
      s_next.p0_oe  = 8'h00;
      s_next.p2_out = ext_bus_pkg::PORT_RESET;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      s_reg              <= '0;
      s_reg.mode         <= ext_bus_pkg::ST_RESET;
      s_reg.ea_latched_n <= 1'b1;
      s_reg.strobe_prev  <= 1'b1;
      s_reg.program_fetch_strobe_n_n       <= 1'b1;
      s_reg.rd_n         <= 1'b1;
      s_reg.wr_n         <= 1'b1;
      s_reg.p2_out       <= ext_bus_pkg::PORT_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  logic host;
  assign host = (s_reg.mode == ext_bus_pkg::ST_HOST_PROGRAM_PULSE_N);

  assign P0_OUT  = s_reg.p0_out;
  assign P0_OE   = s_reg.p0_oe;
  assign P2_OUT  = s_reg.p2_out;
  assign P3_OUT  = {s_reg.rd_n, s_reg.wr_n, 4'hf, SERIAL_OUT, 1'b1};
  assign SERIAL_IN    = p3_s[0];
  assign EXT_IRQ0_N   = p3_s[2];
  assign EXT_IRQ1_N   = p3_s[3];
  assign TIMER0_INPUT = p3_s[4];
  assign TIMER1_INPUT = p3_s[5];
  assign ALE_OUT = s_reg.ale;
  assign ALE_OE  = !host;
  assign PROGRAM_PULSE_N = host ? ale_s : 1'b1;
  assign PROGRAM_FETCH_STROBE_N_OUT = s_reg.program_fetch_strobe_n_n;
  assign PROGRAM_FETCH_STROBE_N_OE  = (s_reg.mode == ext_bus_pkg::ST_RUN);
  assign PROGRAM_PULSE_N_ADDR = host ? {p3_s[7:6], p2_s[5:0], p1_s} : 16'h0000;
  assign PROGRAM_PULSE_N_CODE = host ? p0_s : 8'h00;
  assign EXT_FETCH_ACTIVE = !ea_eff_n;
  assign HOST_PROGRAM_PULSE_N_MODE   = host;
  assign IN_RESET = (s_reg.mode == ext_bus_pkg::ST_RESET) ||
                    (s_reg.mode == ext_bus_pkg::ST_RESET_DONE);
endmodule // ext_memory_bus

/* File: testbench/ext_mem_model.sv */
// far-side memory: address latch, 64K code store and 64K data store
// assumes the bench resolves the port_zero wire and feeds it back here
module ext_mem_model (
  input  wire logic       clk,
  input  wire logic       ale,
  input  wire logic [7:0] p0_pin,
  input  wire logic [7:0] p2_pin,
  input  wire logic       fetch_n,
  input  wire logic       read_n,
  input  wire logic       write_n,
  output logic      [7:0] p0_drive
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  code_mem [65536];
  logic [7:0]  data_mem [65536];
  logic [7:0]  low_addr = 8'h00;
  logic [7:0]  last = 8'h00;
  logic [15:0] addr;
  initial begin
    foreach (code_mem[i]) begin
      code_mem[i] = i[7:0] ^ i[15:8];
      data_mem[i] = ~code_mem[i];
    end
  end
  assign addr = {p2_pin, low_addr};
  always @(negedge ale) low_addr <= p0_pin;
  always @(posedge clk) begin
    last <= p0_pin;
    if (!write_n) data_mem[addr] <= p0_pin;
  end
  // a released bus shows a changing pattern, never the last byte
  assign p0_drive = !fetch_n ? code_mem[addr] :
                    !read_n  ? data_mem[addr] : ~last;
endmodule // ext_mem_model

/* File: testbench/ext_memory_bus_and_reset_entry_tb.sv */
// self-checking bench for ext_memory_bus: bus cycles, fifo, reset entry
// assumes the memory model and the bound checker are compiled with it
module ext_memory_bus_and_reset_entry_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [1:0] FET  = ext_bus_pkg::ACC_FETCH;
  localparam logic [1:0] WIDE = ext_bus_pkg::ACC_WIDE_MOVE;
  localparam logic [1:0] NARR = ext_bus_pkg::ACC_NARROW_MOVE;
  logic        clk = 1'b0;
  logic        rst_n, rst_pin, sel_n, lock, req_valid, req_write, req_int;
  logic        rd_ready, host_drv, verify, ale_tb, program_fetch_strobe_n_tb, req_ready;
  logic        rdata_valid, ale_out, ale_oe, program_fetch_strobe_n_out, program_fetch_strobe_n_oe, host_mode;
  logic        in_reset, pulse_n, ser_in, irq0_n, irq1_n, t0_in, t1_in;
  logic        ext_act;
  logic [1:0]  req_kind;
  logic [7:0]  req_wdata, p0_latch, p2_latch, p1_in, p2_in, p3_in, p0_host;
  logic [7:0]  rdata, p0_out, p0_oe, p2_out, p3_out, program_pulse_n_code, mdrv, p0_pin;
  logic [15:0] req_addr, program_pulse_n_addr;
  int          n_fail = 0;
  int          checked = 0;
  int          n_program_fetch_strobe_n = 0;
  int          n_ale = 0;
  assign p0_pin = host_drv ? p0_host : (p0_oe & p0_out) | (~p0_oe & mdrv);
  always #4 clk = ~clk;
  always @(negedge program_fetch_strobe_n_out) n_program_fetch_strobe_n++;
  always @(posedge ale_out) n_ale++;
  ext_memory_bus ext_memory_bus_i (.CLK(clk), .RST_N(rst_n),
    .RST_PIN(rst_pin), .EXT_FETCH_SELECT_N(sel_n), .SECURITY_LOCK(lock),
    .REQ_VALID(req_valid), .REQ_READY(req_ready), .REQ_KIND(req_kind),
    .REQ_WRITE(req_write), .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata),
    .REQ_INTERNAL(req_int), .RDATA(rdata), .RDATA_VALID(rdata_valid),
    .RDATA_READY(rd_ready), .PORT_ZERO_LATCH(p0_latch),
    .PORT_TWO_LATCH(p2_latch), .SERIAL_OUT(1'b1), .SERIAL_IN(ser_in),
    .EXT_IRQ0_N(irq0_n), .EXT_IRQ1_N(irq1_n), .TIMER0_INPUT(t0_in),
    .TIMER1_INPUT(t1_in), .P0_IN(p0_pin), .P0_OUT(p0_out), .P0_OE(p0_oe),
    .P2_OUT(p2_out), .P3_OUT(p3_out), .P1_IN(p1_in), .P2_IN(p2_in),
    .P3_IN(p3_in), .ALE_OUT(ale_out), .ALE_OE(ale_oe),
    .ALE_IN(ale_oe ? ale_out : ale_tb), .PROGRAM_FETCH_STROBE_N_OUT(program_fetch_strobe_n_out),
    .PROGRAM_FETCH_STROBE_N_OE(program_fetch_strobe_n_oe),
    .PROGRAM_FETCH_STROBE_N_IN(program_fetch_strobe_n_oe ? program_fetch_strobe_n_out : program_fetch_strobe_n_tb),
    .EXT_FETCH_ACTIVE(ext_act), .HOST_PROGRAM_PULSE_N_MODE(host_mode),
    .IN_RESET(in_reset),
    .PROGRAM_PULSE_N(pulse_n), .PROGRAM_PULSE_N_ADDR(program_pulse_n_addr), .PROGRAM_PULSE_N_CODE(program_pulse_n_code),
    .PROGRAM_PULSE_N_VERIFY_DATA(8'h96), .PROGRAM_PULSE_N_VERIFY(verify));
  ext_mem_model ext_mem_model_i (.clk(clk), .ale(ale_out), .p0_pin(p0_pin),
    .p2_pin(p2_out), .fetch_n(program_fetch_strobe_n_out), .read_n(p3_out[7]),
    .write_n(p3_out[6]), .p0_drive(mdrv));
  function automatic logic [7:0] cf(input logic [15:0] a);
    return a[7:0] ^ a[15:8];
  endfunction
  task automatic chk(input string what, input logic [23:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize;
    if (n_fail == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic boot(input int hold, input logic host);
    rst_n = 1'b0; rst_pin = 1'b1; program_fetch_strobe_n_tb = 1'b1; cyc(3);
    rst_n = 1'b1; cyc(hold);
    if (host) program_fetch_strobe_n_tb = 1'b0;
    else rst_pin = 1'b0;
    cyc(8);
  endtask
  task automatic req(input logic [1:0] k, input logic w,
                     input logic [15:0] a, input logic [7:0] d);
    req_kind = k; req_write = w; req_addr = a; req_wdata = d;
    req_valid = 1'b1;
    for (int i = 0; i < 40 && req_ready !== 1'b1; i++) cyc(1);
    chk("request accepted", req_ready, 1'b1);
    cyc(1); req_valid = 1'b0; cyc(6);
  endtask
  task automatic pop(input logic [7:0] e, input string what);
    for (int i = 0; i < 20 && rdata_valid !== 1'b1; i++) cyc(1);
    chk(what, rdata, e);
    rd_ready = 1'b1; cyc(1); rd_ready = 1'b0; cyc(1);
  endtask
  task automatic t_reset;
    cyc(3);
    chk("reset pins", {p0_oe, p2_out, program_fetch_strobe_n_out, p3_out[7:6], ale_out},
        {8'h00, 8'hff, 4'he});
    rst_n = 1'b1; rst_pin = 1'b1; cyc(6); rst_pin = 1'b0; cyc(8);
    chk("short reset pulse", in_reset, 1'b1);
    boot(14, 1'b0);
    chk("normal mode", {in_reset, host_mode}, 2'b00);
  endtask
  task automatic t_fetch;
    logic [15:0] a [8] = '{16'h0000, 16'hffff, 16'h1234, 16'h8001,
                           16'h7ffe, 16'h00ff, 16'hff00, 16'h5aa5};
    sel_n = 1'b0; req_int = 1'b1; cyc(8); n_program_fetch_strobe_n = 0;
    foreach (a[i]) req(FET, 1'b0, a[i], 8'h00);
    chk("full fifo refuses", req_ready, 1'b0);
    chk("fetch strobes", n_program_fetch_strobe_n, 16'd16);
    foreach (a[i]) pop(cf(a[i]), "fetched byte");
  endtask
  task automatic t_data;
    p2_latch = 8'h7e; n_program_fetch_strobe_n = 0;
    req(WIDE, 1'b1, 16'hbeef, 8'h3c);
    req(NARR, 1'b1, 16'h9942, 8'hc5);
    req(WIDE, 1'b0, 16'hbeef, 8'h00); pop(8'h3c, "wide read");
    req(WIDE, 1'b0, 16'h7e42, 8'h00); pop(8'hc5, "narrow page");
    req(NARR, 1'b0, 16'h0042, 8'h00); pop(8'hc5, "narrow read");
    req(WIDE, 1'b0, 16'h1234, 8'h00); pop(~cf(16'h1234), "old data");
    chk("no fetch strobe in data moves", n_program_fetch_strobe_n, 16'd0);
  endtask
  task automatic t_quiet;
    sel_n = 1'b1; p0_latch = 8'h0f; cyc(8); n_program_fetch_strobe_n = 0; n_ale = 0;
    req(FET, 1'b0, 16'h0100, 8'h00);
    chk("internal fetch quiet", {n_program_fetch_strobe_n[7:0], n_ale[7:0]}, 16'h0);
    chk("written ones float", p0_oe & 8'h0f, 8'h00);
    for (int i = 0; i < 2; i++) begin
      p3_in = i ? 8'h15 : 8'h2a; cyc(4);
      chk("port three inputs", {t1_in, t0_in, irq1_n, irq0_n, ser_in},
          {p3_in[5:2], p3_in[0]});
    end
  endtask
  task automatic t_lock;
    lock = 1'b1; boot(14, 1'b0); sel_n = 1'b0; cyc(8); n_program_fetch_strobe_n = 0;
    req(FET, 1'b0, 16'h0200, 8'h00);
    chk("locked select", n_program_fetch_strobe_n, 16'd0);
    chk("locked fetch flag", ext_act, 1'b0);
    lock = 1'b0; sel_n = 1'b1; boot(14, 1'b0); sel_n = 1'b0; cyc(8);
    n_program_fetch_strobe_n = 0;
    req(FET, 1'b0, 16'h0200, 8'h00);
    chk("live select", n_program_fetch_strobe_n, 16'd2);
    chk("live fetch flag", ext_act, 1'b1);
    pop(cf(16'h0200), "fetch after unlock");
  endtask
  task automatic t_host;
    boot(100, 1'b1);
    chk("host mode", host_mode, 1'b1);
    p1_in = 8'h5a; p2_in = 8'h2c; p3_in = 8'h80;
    host_drv = 1'b1; p0_host = 8'h3e; ale_tb = 1'b0; cyc(4);
    chk("program pulse", pulse_n, 1'b0);
    chk("program address", program_pulse_n_addr, 16'hac5a);
    chk("code in", program_pulse_n_code, 8'h3e);
    host_drv = 1'b0; verify = 1'b1; cyc(4);
    chk("verify out", {p0_oe, p0_out}, 16'hff96);
  endtask
  initial begin
    {rst_n, rst_pin, sel_n, lock, req_valid, req_write, req_int} = '0;
    {rd_ready, host_drv, verify, ale_tb, program_fetch_strobe_n_tb} = 5'b00011;
    {req_kind, req_addr, req_wdata, p0_latch, p2_latch} = '0;
    {p1_in, p2_in, p3_in, p0_host} = '0;
    t_reset;
    t_fetch;
    t_data;
    t_quiet;
    t_lock;
    t_host;
    summarize;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    summarize;
  end
endmodule // ext_memory_bus_and_reset_entry_tb

/* File: testbench/ext_memory_bus_assertions.sv */
// checker for ext_memory_bus: strobe timing, address phase, reset entry
// assumes it is bound to ext_memory_bus and sees only its ports
module ext_memory_bus_assertions (
  input wire logic        CLK,
  input wire logic        RST_N,
  input wire logic        RST_PIN,
  input wire logic        EXT_FETCH_SELECT_N,
  input wire logic        REQ_VALID,
  input wire logic        REQ_READY,
  input wire logic [1:0]  REQ_KIND,
  input wire logic        REQ_INTERNAL,
  input wire logic [15:0] REQ_ADDR,
  input wire logic [7:0]  PORT_TWO_LATCH,
  input wire logic [7:0]  P0_OUT,
  input wire logic [7:0]  P0_OE,
  input wire logic [7:0]  P2_OUT,
  input wire logic [7:0]  P3_OUT,
  input wire logic        ALE_OUT,
  input wire logic        ALE_OE,
  input wire logic        PROGRAM_FETCH_STROBE_N_OUT,
  input wire logic        HOST_PROGRAM_PULSE_N_MODE,
  input wire logic        IN_RESET,
  input wire logic        PROGRAM_PULSE_N
);
  logic [7:0] hi_reg;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // saturating count of consecutive cycles with the reset pin high
  always_ff @(posedge CLK or negedge RST_N)
    if (!RST_N) hi_reg <= 8'h00;
    else if (!RST_PIN) hi_reg <= 8'h00;
    else if (hi_reg != 8'hff) hi_reg <= hi_reg + 8'h01;
  AST_ADDR_HOLD: assert property ($fell(ALE_OUT) |->
    P0_OE == 8'hff && $stable(P0_OUT)) else $error("address moved at latch");
  AST_ALE_DRIVE: assert property (ALE_OUT |-> P0_OE == 8'hff && ALE_OE)
    else $error("port zero not driven in address phase");
  AST_FETCH_PAIR: assert property (
    $fell(PROGRAM_FETCH_STROBE_N_OUT) && $past(ALE_OUT, 2) |->
    ##1 PROGRAM_FETCH_STROBE_N_OUT ##1 !PROGRAM_FETCH_STROBE_N_OUT
    ##1 PROGRAM_FETCH_STROBE_N_OUT) else $error("fetch strobe pair wrong");
  AST_FETCH_SLOT: assert property (
    $fell(PROGRAM_FETCH_STROBE_N_OUT) |-> $past(ALE_OUT, 2) || $past(ALE_OUT, 4))
    else $error("fetch strobe without latch pulse");
  AST_READ_SKIP: assert property ($fell(P3_OUT[7]) |->
    (!P3_OUT[7] && PROGRAM_FETCH_STROBE_N_OUT)[*3] ##1 P3_OUT[7])
    else $error("read strobe shape or fetch strobe overlap");
  AST_WRITE_DATA: assert property ($fell(P3_OUT[6]) |->
    P0_OE == 8'hff && PROGRAM_FETCH_STROBE_N_OUT
    ##1 ($stable(P0_OUT) && !P3_OUT[6])[*2]) else $error("write data moved");
  AST_INTERNAL_QUIET: assert property (REQ_VALID && REQ_READY &&
    REQ_KIND == 2'h0 && REQ_INTERNAL && EXT_FETCH_SELECT_N |->
    (PROGRAM_FETCH_STROBE_N_OUT && !ALE_OUT)[*6])
    else $error("internal fetch showed on pins");
  AST_WIDE_HIGH: assert property (REQ_VALID && REQ_READY &&
    REQ_KIND == 2'h1 |-> ##2 P2_OUT == $past(REQ_ADDR[15:8], 2))
    else $error("high address missing on port two");
  AST_NARROW_LATCH: assert property (REQ_VALID && REQ_READY &&
    REQ_KIND == 2'h2 |-> ##1 (P2_OUT == PORT_TWO_LATCH)[*6])
    else $error("port two left its latch in narrow move");
  AST_RESET_HOLD: assert property (hi_reg >= 8'h10 |->
    IN_RESET || HOST_PROGRAM_PULSE_N_MODE) else $error("long reset pin ignored");
  AST_HOST_ENTRY: assert property ($rose(HOST_PROGRAM_PULSE_N_MODE) |->
    hi_reg > 8'h3c) else $error("host mode without long reset");
  AST_PULSE_HOST: assert property (!PROGRAM_PULSE_N |->
    HOST_PROGRAM_PULSE_N_MODE && !ALE_OE) else $error("program pulse outside host mode");
endmodule // ext_memory_bus_assertions

bind ext_memory_bus ext_memory_bus_assertions ext_memory_bus_assertions_i (
  .CLK, .RST_N, .RST_PIN, .EXT_FETCH_SELECT_N, .REQ_VALID, .REQ_READY,
  .REQ_KIND, .REQ_INTERNAL, .REQ_ADDR, .PORT_TWO_LATCH, .P0_OUT, .P0_OE,
  .P2_OUT, .P3_OUT, .ALE_OUT, .ALE_OE, .PROGRAM_FETCH_STROBE_N_OUT,
  .HOST_PROGRAM_PULSE_N_MODE, .IN_RESET, .PROGRAM_PULSE_N);
